// *** common/bf_defines.svh ***
/*
 Constants of the breaker-failure supervision block: register offsets,
 field positions, reset values, limits and timing counts.
 Assumes inclusion by bare name from the package and bf_supervisor.
*/
`ifndef BF_DEFINES_SVH
`define BF_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define BF_OFS_CTRL      8'h00
`define BF_OFS_PHASE_THR 8'h04
`define BF_OFS_RES_THR   8'h08
`define BF_OFS_RT_DELAY  8'h0C
`define BF_OFS_BF_DELAY  8'h10
`define BF_OFS_STATUS    8'h14
`define BF_OFS_TIMER     8'h18

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define BF_CTRL_RES_LO   0
`define BF_CTRL_RES_HI   1
`define BF_CTRL_MODE_LO  2
`define BF_CTRL_MODE_HI  5
`define BF_CTRL_RT_EN    8

// ----------------------------------------------------------------------
// Widths, reset values and limits
// ----------------------------------------------------------------------
`define BF_PH_W          12
`define BF_RES_W         16
`define BF_DLY_W         19
`define BF_CNT_W         16
`define BF_PH_SCALE      10
`define BF_REL_PCT       97
`define BF_PH_RST        12'h014
`define BF_PH_MIN        12'h001
`define BF_PH_MAX        12'hFA0
`define BF_RES_RST       16'h04B0
`define BF_RES_MIN       16'h0005
`define BF_RES_MAX       16'h9C40
`define BF_RT_RST        19'h00014
`define BF_BF_RST        19'h00028
`define BF_DLY_MAX       19'h57E40
`define BF_RT_EN_RST     1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BF_CLK_NS        100
`define BF_TICK_NS       5000000
`define BF_TICK_CYCLES   (`BF_TICK_NS / `BF_CLK_NS)

`endif

// *** common/bf_pkg.sv ***
/*
 Types of the breaker-failure supervision block.
 Assumes the constants header is on the include path.
*/
`include "bf_defines.svh"

package bf_pkg;

    // ------------------------------------------------------------------
    // Selectors and condition
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RES_NONE = 2'h0,
        RES_FIRST = 2'h1,
        RES_SECOND = 2'h2,
        RES_CALC = 2'h3
    } res_sel_e;

    typedef enum logic [3:0] {
        MODE_CUR = 4'h0,
        MODE_DO = 4'h1,
        MODE_SIG = 4'h2,
        MODE_CUR_AND_DO = 4'h3,
        MODE_CUR_OR_DO = 4'h4,
        MODE_CUR_AND_SIG = 4'h5,
        MODE_CUR_OR_SIG = 4'h6,
        MODE_SIG_AND_DO = 4'h7,
        MODE_SIG_OR_DO = 4'h8,
        MODE_ALL_AND = 4'h9,
        MODE_ALL_OR = 4'hA
    } mode_e;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_STARTED = 3'h1,
        COND_RETRIP = 3'h3,
        COND_BF_ON = 3'h2,
        COND_BLOCKED = 3'h6
    } cond_e;

    // ------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic picked;
    } pick_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0] res_sel;
        logic [3:0] mode;
        logic retrip_en;
        logic [`BF_PH_W-1:0] ph_thr;
        logic [`BF_RES_W-1:0] res_thr;
        logic [`BF_DLY_W-1:0] rt_dly;
        logic [`BF_DLY_W-1:0] bf_dly;
        logic [`BF_CNT_W-1:0] tick_cnt;
        logic tick;
        logic eval;
        logic blk;
        cond_e state;
        logic [`BF_DLY_W-1:0] timer;
        logic start;
        logic blocked;
        logic retrip;
        logic bf;
    } bf_s;

endpackage

// *** design/bf_pickup.sv ***
/*
 One pick-up element: compares a magnitude with its pick-up level at each
 processing tick and holds the pick-up until the magnitude drops below
 the release level or ENABLE goes low.
 Assumes the tick is a one-cycle pulse and both levels are in the
 magnitude's units.
*/
`timescale 1ns/1ps

module bf_pickup #(
    parameter int MAG_W = 16
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic TICK,
    input wire logic ENABLE,
    input wire logic [MAG_W-1:0] MAGNITUDE,
    input wire logic [MAG_W-1:0] PICK_LEVEL,
    input wire logic [MAG_W-1:0] RELEASE_LEVEL,
    output logic PICKED
);
    import bf_pkg::*;

    pick_s st_ff;
    pick_s nxt_st;

    // ------------------------------------------------------------------
    // Hysteresis
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (!ENABLE) begin
            nxt_st.picked = 1'b0;
        end else if (TICK) begin
            if (MAGNITUDE > PICK_LEVEL) begin
                nxt_st.picked = 1'b1; // [R1]
            end else if (MAGNITUDE < RELEASE_LEVEL) begin
                nxt_st.picked = 1'b0; // [R2]
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign PICKED = st_ff.picked;

endmodule

// *** design/bf_supervisor.sv ***
/*
 Breaker-failure supervision: current pick-up on three phases and a
 selectable residual input, blocking, and the retrip and breaker-failure
 delay timers, with settings and status on a classic Wishbone slave.
 Assumes all inputs are synchronous to CLK and magnitudes are given in
 units of 0.001 of nominal current, refreshed at least once per tick.
*/
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "bf_defines.svh"

// Contract
// R1 - Pick-up when any phase or the chosen residual exceeds its threshold.
// R2 - Release only below 97 percent of the phase threshold, fixed ratio.
// R3 - One phase threshold is shared by all three phases.
// R4 - Residual source: none, first, second or calculated; resets to none.
// R5 - Mode selects current, signal, output state or combinations; resets to current.
// R6 - Phase threshold in 0.01 nominal steps, at most 40, reset 0.20.
// R7 - Residual threshold in 0.001 nominal steps, reset 1.200.
// R8 - Read-only condition: normal, started, retrip, breaker failure or blocked.
// R9 - Blocking input sampled once at the start of each processing cycle.
// R10 - Pick-up without blocking raises start and runs the delays.
// R11 - Pick-up with blocking raises blocked; no timers, no further outputs.
// R12 - Blocking after start clears start and releases as on pick-up drop.
// R13 - Blocking source asserts blocking at least 5 ms before delay expiry.
// R14 - Retrip and breaker-failure timers start together from one pick-up.
// R15 - Retrip delay plus breaker and release times should undercut failure delay.
// R16 - Retrip enable resets enabled; disabled suppresses the retrip output.
// R17 - Retrip output after start lasts the retrip delay; 5 ms steps, reset 0.100 s.
// R18 - Failure output after start lasts the failure delay; 5 ms steps, reset 0.200 s.
// R19 - Setting changes are accepted while running and then applied.
// R20 - Magnitudes are processed on a 5 ms time base.
// R21 - Pick-up release clears both timers and both outputs.
// R22 - Timers advance once per 5 ms tick and compare against delays in ticks.
module bf_supervisor #(
    parameter int MAG_W = 16,
    parameter int TICK_CYCLES = `BF_TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic [MAG_W-1:0] PHASE_A_MAG,
    input wire logic [MAG_W-1:0] PHASE_B_MAG,
    input wire logic [MAG_W-1:0] PHASE_C_MAG,
    input wire logic [MAG_W-1:0] FIRST_RESIDUAL_INPUT,
    input wire logic [MAG_W-1:0] SECOND_RESIDUAL_INPUT,
    input wire logic [MAG_W-1:0] CALCULATED_RESIDUAL,
    input wire logic BLOCK_IN,
    input wire logic SIGNAL_TRIP,
    input wire logic DO_CLOSED,
    output logic START,
    output logic BLOCKED,
    output logic RETRIP,
    output logic BREAKER_FAILURE_OUTPUT,
    output bf_pkg::cond_e CONDITION
);
    import bf_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Thresholds reach 40000 in magnitude units, so narrower magnitudes cannot hold them.
    if (MAG_W < 16 || MAG_W > 24) begin : g_bad_mag
        $error("MAG_W must lie between 16 and 24");
    end
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("TICK_CYCLES must lie between 2 and 65536");
    end

    localparam logic [`BF_CNT_W-1:0] TICK_LAST = `BF_CNT_W'(TICK_CYCLES - 1);

    bf_s st_ff;
    bf_s nxt_st;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        logic [31:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic logic trig(input logic [3:0] mode, input logic cur, input logic sig,
                                  input logic dout);
        logic r;
        r = cur;
        case (mode)
            MODE_DO: r = dout;
            MODE_SIG: r = sig;
            MODE_CUR_AND_DO: r = cur & dout;
            MODE_CUR_OR_DO: r = cur | dout;
            MODE_CUR_AND_SIG: r = cur & sig;
            MODE_CUR_OR_SIG: r = cur | sig;
            MODE_SIG_AND_DO: r = sig & dout;
            MODE_SIG_OR_DO: r = sig | dout;
            MODE_ALL_AND: r = cur & sig & dout;
            MODE_ALL_OR: r = cur | sig | dout;
            default: r = cur;
        endcase
        return r;
    endfunction

    function automatic logic running(input cond_e s);
        return (s == COND_STARTED) || (s == COND_RETRIP) || (s == COND_BF_ON);
    endfunction

    // ------------------------------------------------------------------
    // Pick-up elements
    // ------------------------------------------------------------------
    logic [MAG_W-1:0] ph_mag [3];
    logic [MAG_W-1:0] res_mag;
    logic [MAG_W-1:0] ph_level;
    logic [MAG_W-1:0] res_level;
    logic [MAG_W-1:0] rel_level;
    logic [2:0] ph_pick;
    logic res_pick;
    logic cur_pick;

    assign ph_mag[0] = PHASE_A_MAG;
    assign ph_mag[1] = PHASE_B_MAG;
    assign ph_mag[2] = PHASE_C_MAG;
    // One phase level in magnitude units serves all three phases.
    assign ph_level = MAG_W'(st_ff.ph_thr * `BF_PH_SCALE); // [R3] [R6]
    assign res_level = MAG_W'(st_ff.res_thr); // [R7]
    // The release level follows the phase setting for the residual element too.
    assign rel_level = MAG_W'((st_ff.ph_thr * `BF_PH_SCALE * `BF_REL_PCT) / 100); // [R2]

    always_comb begin
        unique case (res_sel_e'(st_ff.res_sel))
            RES_FIRST: res_mag = FIRST_RESIDUAL_INPUT;
            RES_SECOND: res_mag = SECOND_RESIDUAL_INPUT;
            RES_CALC: res_mag = CALCULATED_RESIDUAL;
            RES_NONE: res_mag = '0;
        endcase
    end

    for (genvar g = 0; g < 3; g++) begin : g_phase
        bf_pickup #(.MAG_W(MAG_W)) u_phase (
            .CLK(CLK),
            .RESET(RESET),
            .TICK(st_ff.tick),
            .ENABLE(1'b1),
            .MAGNITUDE(ph_mag[g]),
            .PICK_LEVEL(ph_level),
            .RELEASE_LEVEL(rel_level),
            .PICKED(ph_pick[g])
        );
    end

    bf_pickup #(.MAG_W(MAG_W)) u_residual (
        .CLK(CLK),
        .RESET(RESET),
        .TICK(st_ff.tick),
        .ENABLE(st_ff.res_sel != RES_NONE), // [R4]
        .MAGNITUDE(res_mag),
        .PICK_LEVEL(res_level),
        .RELEASE_LEVEL(rel_level),
        .PICKED(res_pick)
    );

    // Any one, two or all phases, or the residual, pick up the element.
    assign cur_pick = (|ph_pick) | res_pick; // [R1]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] w;
        logic pick;
        logic [`BF_DLY_W-1:0] t;
        w = '0;
        pick = 1'b0;
        t = '0;
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.tick = 1'b0;
        // Pick-up elements settle on the tick, so the sequence looks one cycle later.
        nxt_st.eval = st_ff.tick;

        // Processing tick.
        if (st_ff.tick_cnt == TICK_LAST) begin
            nxt_st.tick_cnt = '0;
            nxt_st.tick = 1'b1; // [R20] [R22]
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + `BF_CNT_W'(1);
        end
        if (st_ff.tick) begin
            nxt_st.blk = BLOCK_IN; // [R9]
        end

        // Wishbone slave; settings written mid-run act from the next tick.
        if (CYC_I && STB_I && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = '0;
            if (WE_I) begin
                unique case (ADR_I)
                    `BF_OFS_CTRL: begin
                        w = merge({23'h0, st_ff.retrip_en, 2'h0, st_ff.mode, st_ff.res_sel}, DAT_I, SEL_I);
                        nxt_st.res_sel = w[`BF_CTRL_RES_HI:`BF_CTRL_RES_LO]; // [R4] [R19]
                        nxt_st.mode = w[`BF_CTRL_MODE_HI:`BF_CTRL_MODE_LO]; // [R5]
                        nxt_st.retrip_en = w[`BF_CTRL_RT_EN]; // [R16]
                    end
                    `BF_OFS_PHASE_THR: begin
                        w = merge({20'h0, st_ff.ph_thr}, DAT_I, SEL_I);
                        nxt_st.ph_thr = `BF_PH_W'(clamp(w, 32'(`BF_PH_MIN), 32'(`BF_PH_MAX))); // [R6]
                    end
                    `BF_OFS_RES_THR: begin
                        w = merge({16'h0, st_ff.res_thr}, DAT_I, SEL_I);
                        nxt_st.res_thr = `BF_RES_W'(clamp(w, 32'(`BF_RES_MIN), 32'(`BF_RES_MAX))); // [R7]
                    end
                    `BF_OFS_RT_DELAY: begin
                        w = merge({13'h0, st_ff.rt_dly}, DAT_I, SEL_I);
                        nxt_st.rt_dly = `BF_DLY_W'(clamp(w, 32'h0, 32'(`BF_DLY_MAX))); // [R17]
                    end
                    `BF_OFS_BF_DELAY: begin
                        w = merge({13'h0, st_ff.bf_dly}, DAT_I, SEL_I);
                        nxt_st.bf_dly = `BF_DLY_W'(clamp(w, 32'h0, 32'(`BF_DLY_MAX))); // [R18]
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (ADR_I)
                    `BF_OFS_CTRL: nxt_st.rdata = {23'h0, st_ff.retrip_en, 2'h0, st_ff.mode, st_ff.res_sel};
                    `BF_OFS_PHASE_THR: nxt_st.rdata = {20'h0, st_ff.ph_thr};
                    `BF_OFS_RES_THR: nxt_st.rdata = {16'h0, st_ff.res_thr};
                    // The retrip delay reads as zero while retrip is disabled.
                    `BF_OFS_RT_DELAY: nxt_st.rdata = st_ff.retrip_en ? {13'h0, st_ff.rt_dly} : 32'h0; // [R16]
                    `BF_OFS_BF_DELAY: nxt_st.rdata = {13'h0, st_ff.bf_dly};
                    `BF_OFS_STATUS: nxt_st.rdata = {24'h0, st_ff.bf, st_ff.retrip, st_ff.start, st_ff.blk,
                                                    cur_pick, st_ff.state}; // [R8]
                    `BF_OFS_TIMER: nxt_st.rdata = {13'h0, st_ff.timer};
                    default: nxt_st.rdata = '0;
                endcase
            end
        end

        // Supervision sequence, once per processing cycle.
        if (st_ff.eval) begin
            pick = trig(st_ff.mode, cur_pick, SIGNAL_TRIP, DO_CLOSED); // [R5]
            unique case (st_ff.state)
                COND_NORMAL, COND_BLOCKED: begin
                    nxt_st.timer = '0;
                    if (!pick) begin
                        nxt_st.state = COND_NORMAL;
                    end else if (st_ff.blk) begin
                        nxt_st.state = COND_BLOCKED; // [R11]
                    end else begin
                        nxt_st.state = COND_STARTED; // [R10] [R14]
                    end
                end
                COND_STARTED, COND_RETRIP, COND_BF_ON: begin
                    if (!pick) begin
                        nxt_st.state = COND_NORMAL; // [R21]
                        nxt_st.timer = '0;
                    end else if (st_ff.blk) begin
                        // The blocking source must act 5 ms ahead, else an output may already be set.
                        nxt_st.state = COND_BLOCKED; // [R12] [R13]
                        nxt_st.timer = '0;
                    end else begin
                        t = (st_ff.timer == `BF_DLY_MAX) ? st_ff.timer : st_ff.timer + `BF_DLY_W'(1);
                        nxt_st.timer = t; // [R22]
                        if (t >= st_ff.bf_dly) begin
                            nxt_st.state = COND_BF_ON;
                        end else if (st_ff.retrip_en && t >= st_ff.rt_dly) begin
                            nxt_st.state = COND_RETRIP;
                        end else begin
                            nxt_st.state = COND_STARTED;
                        end
                    end
                end
                default: begin
                    nxt_st.state = COND_NORMAL;
                    nxt_st.timer = '0;
                end
            endcase
            // Both outputs come from one timer, so they share a single start instant.
            nxt_st.start = running(nxt_st.state); // [R10] [R12]
            nxt_st.blocked = (nxt_st.state == COND_BLOCKED); // [R11]
            nxt_st.retrip = (nxt_st.state inside {COND_RETRIP, COND_BF_ON}) && st_ff.retrip_en
                            && (nxt_st.timer >= st_ff.rt_dly); // [R16] [R17]
            nxt_st.bf = (nxt_st.state == COND_BF_ON); // [R18] [R21]
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_ff <= '0;
            st_ff.res_sel <= RES_NONE; // [R4]
            st_ff.mode <= MODE_CUR; // [R5]
            st_ff.retrip_en <= `BF_RT_EN_RST; // [R16]
            st_ff.ph_thr <= `BF_PH_RST; // [R6]
            st_ff.res_thr <= `BF_RES_RST; // [R7]
            st_ff.rt_dly <= `BF_RT_RST; // [R17]
            st_ff.bf_dly <= `BF_BF_RST; // [R18]
            st_ff.state <= COND_NORMAL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign DAT_O = st_ff.rdata;
    assign ACK_O = st_ff.ack;
    assign START = st_ff.start;
    assign BLOCKED = st_ff.blocked;
    assign RETRIP = st_ff.retrip;
    assign BREAKER_FAILURE_OUTPUT = st_ff.bf;
    assign CONDITION = st_ff.state; // [R8]

endmodule

// *** dv/bf_far_side.sv ***
/* Far-side model: blocking matrix, protection trip signal and output contact.
 Assumes commands come from the bench in step with clk. */
`timescale 1ns/1ps
module bf_far_side (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [2:0] req,
    output logic block_in,
    output logic signal_trip,
    output logic do_closed
);
    logic [2:0] req_ff;
    logic [2:0] out_ff;
    // With slow set, all three outputs lag one more clock, as a real relay closes late.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_ff <= 3'h0;
            out_ff <= 3'h0;
        end else begin
            req_ff <= req;
            out_ff <= slow ? req_ff : req;
        end
    end
    // Blocking follows its command within two clocks, well before expiry.
    assign {do_closed, signal_trip, block_in} = out_ff;
endmodule

// *** dv/bf_supervisor_sva.sv ***
/* Assertions on the bus answer and the supervision outputs.
 Assumes it sees only the top ports; the tick spacing assumes eight clocks. */
`timescale 1ns/1ps
module bf_supervisor_sva #(
    parameter int TICK_CYCLES = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic ACK_O,
    input wire logic START,
    input wire logic BLOCKED,
    input wire logic RETRIP,
    input wire logic BREAKER_FAILURE_OUTPUT,
    input wire bf_pkg::cond_e CONDITION
);
    import bf_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_req; CYC_I && STB_I && !ACK_O; endsequence
    sequence s_ack; ACK_O ##1 !ACK_O; endsequence
    a_ack_single: assert property (s_req |=> s_ack)
        else $error("bus answer is not a single ack");
    a_start_blocked: assert property (!(START && BLOCKED))
        else $error("start and blocked together");
    a_blocked_cond: assert property (BLOCKED == (CONDITION == COND_BLOCKED))
        else $error("blocked and condition disagree");
    a_retrip_start: assert property (RETRIP |-> START)
        else $error("retrip without start");
    a_fail_start: assert property (BREAKER_FAILURE_OUTPUT |-> START)
        else $error("failure output without start");
    a_fail_cond: assert property (BREAKER_FAILURE_OUTPUT |-> CONDITION == COND_BF_ON)
        else $error("condition not failure");
    a_retrip_cond: assert property (RETRIP && !BREAKER_FAILURE_OUTPUT |-> CONDITION == COND_RETRIP)
        else $error("condition not retrip");
    // Outputs move only at evaluation, so a change is followed by a quiet tick.
    a_tick_gap: assert property ($changed(START) |=> $stable(START) [*7])
        else $error("start changed twice in one tick");
endmodule
bind bf_supervisor bf_supervisor_sva #(.TICK_CYCLES(TICK_CYCLES)) bf_supervisor_sva_inst (.CLK(CLK),
    .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .START(START), .BLOCKED(BLOCKED),
    .RETRIP(RETRIP), .BREAKER_FAILURE_OUTPUT(BREAKER_FAILURE_OUTPUT), .CONDITION(CONDITION));

// *** dv/tb.sv ***
/* Self-checking bench of bf_supervisor with the far-side model.
 Assumes an eight-clock tick stands in for the 5 ms count. */
`timescale 1ns/1ps
module tb;
    import bf_pkg::*;
    localparam int TK = 8;
    localparam logic [15:0] REL = 16'h0014 * 16'h000A * 16'h0061 / 16'h0064;
    localparam logic [31:0] RV [8] = '{32'h100, 32'h14, 32'h4B0, 32'h14, 32'h28, 32'h0, 32'h0, 32'h0};
    logic CLK = 1'b0, RESET = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0, c, d, g;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q, dout;
    logic [15:0] ma = 16'h0, mb = 16'h0, mc = 16'h0, r1 = 16'h0, r2 = 16'h0, r3 = 16'h0;
    logic [2:0] req = 3'h0;
    logic ack, st, bl, rt, bf, blk, sig, dcl;
    cond_e cond;
    int n_mismatch = 0, checked = 0, p, k;
    time t0;
    always #50 CLK = ~CLK;
    bf_far_side bf_far_side_inst (.clk(CLK), .reset(RESET), .slow(slow), .req(req),
        .block_in(blk), .signal_trip(sig), .do_closed(dcl));
    bf_supervisor #(.MAG_W(16), .TICK_CYCLES(TK)) bf_supervisor_inst (.CLK(CLK), .RESET(RESET),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dout),
        .ACK_O(ack), .PHASE_A_MAG(ma), .PHASE_B_MAG(mb), .PHASE_C_MAG(mc), .FIRST_RESIDUAL_INPUT(r1),
        .SECOND_RESIDUAL_INPUT(r2), .CALCULATED_RESIDUAL(r3), .BLOCK_IN(blk), .SIGNAL_TRIP(sig),
        .DO_CLOSED(dcl), .START(st), .BLOCKED(bl), .RETRIP(rt), .BREAKER_FAILURE_OUTPUT(bf),
        .CONDITION(cond));
    task automatic print_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        int i;
        i = 0;
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= dv;
        do begin
            @(posedge CLK);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 20) begin
            cmp(32'h0, 32'h1);
            print_verdict();
        end
    endtask
    task automatic wt(input logic [1:0] s, input logic v);
        logic [3:0] o;
        int i;
        for (i = 0; i < 400; i++) begin
            o = {bf, rt, bl, st};
            if (o[s] === v) break;
            @(posedge CLK);
        end
        if (i >= 400) begin
            cmp(32'h0, 32'h1);
            print_verdict();
        end
    endtask
    task automatic idle();
        ma <= 16'h0;
        req <= 3'h0;
        {mb, mc, r1, r2, r3} <= 80'h0;
        repeat (3 * TK) @(posedge CLK);
    endtask
    function automatic logic trig(input int m, input logic c, input logic d, input logic s);
        logic [10:0] t;
        t = {c | s | d, c & s & d, s | d, s & d, c | s, c & s, c | d, c & d, s, d, c};
        return m < 11 ? t[m] : c;
    endfunction
    initial begin
        void'($urandom(1));
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0);
            cmp(q, RV[i]);
        end
        wb(1'b1, 8'h04, 32'hFFFF);
        wb(1'b0, 8'h04, 32'h0);
        cmp(q, 32'hFA0);
        wb(1'b1, 8'h04, 32'h14);
        wb(1'b1, 8'h0C, 32'h3);
        wb(1'b1, 8'h10, 32'h6);
        $display("test registers done");
        p = $urandom % 3;
        {ma, mb, mc} <= 48'hC9 << (16 * p);
        wt(2'd0, 1'b1);
        t0 = $time;
        cmp(cond, COND_STARTED);
        wt(2'd2, 1'b1);
        cmp(32'(($time - t0) / 100), 3 * TK);
        wt(2'd3, 1'b1);
        cmp(32'(($time - t0) / 100), 6 * TK);
        {ma, mb, mc} <= 48'(REL) << (16 * p);
        repeat (3 * TK) @(posedge CLK);
        cmp(st, 1'b1);
        {ma, mb, mc} <= 48'(REL - 16'h1) << (16 * p);
        wt(2'd0, 1'b0);
        cmp({rt, bf, cond}, 5'h0);
        $display("test timers done");
        for (int s = 0; s < 4; s++) begin
            k = 1 + $urandom % 3;
            wb(1'b1, 8'h00, 32'h100 | s);
            {r1, r2, r3} <= 48'h4B1 << (16 * (3 - k));
            repeat (3 * TK) @(posedge CLK);
            cmp(st, s == k);
            idle();
        end
        for (int m = 0; m < 16; m++) begin
            {c, d, g} = 3'($urandom);
            slow <= m[0];
            wb(1'b1, 8'h00, 32'h100 | (m << 2));
            ma <= c ? 16'hC9 : 16'h0;
            req <= {d, g, 1'b0};
            repeat (3 * TK) @(posedge CLK);
            cmp(st, trig(m, c, d, g));
            idle();
        end
        $display("test residual and modes done");
        wb(1'b1, 8'h00, 32'h100);
        req <= 3'h1;
        ma <= 16'hC9;
        repeat (3 * TK) @(posedge CLK);
        cmp({st, bl, cond}, {2'b01, COND_BLOCKED});
        req <= 3'h0;
        wt(2'd0, 1'b1);
        req <= 3'h1;
        wt(2'd1, 1'b1);
        cmp({st, rt, bf}, 3'h0);
        idle();
        $display("test blocking done");
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h0C, 32'h0);
        cmp(q, 32'h0);
        ma <= 16'hC9;
        wt(2'd0, 1'b1);
        t0 = $time;
        wb(1'b1, 8'h10, 32'h8);
        wt(2'd3, 1'b1);
        cmp(rt, 1'b0);
        cmp(32'(($time - t0) / 100), 8 * TK);
        idle();
        $display("test retrip off done");
        print_verdict();
    end
endmodule
